/* File: src/wtcm_core.sv */
// Watchdog timer: feed logic, prescaler, down counter, source switch.
// Assumes register strobes and the peripheral clock enable come from
// logic on sys_clk_i; the 400 KHz source is an enable derived here.
//
// Behaviour
// [RULE1] Timeout is 2^(5+tap)*(reload+1)+1 watchdog clock ticks.
// [RULE2] An internal 400 KHz oscillator is one of two clock sources.
// [RULE3] Select 0 takes peripheral clock, select 1 the oscillator.
// [RULE4] New clock select only takes effect after a valid feed.
// [RULE5] Switch: two old ticks to deselect, two new ticks to select.
// [RULE6] Prescaler restarts right after a feed, even mid switch.
// [RULE7] Software keeps the old clock alive two ticks after a feed.
// [RULE8] Wait two peripheral ticks after feed before power-down.
// [RULE9] Switch to oscillator stalls while the peripheral clock stops.
// [RULE10] Timer mode copies control writes to shadow after one tick.
// [RULE11] Counter underflow sets the timeout flag.
// [RULE12] Interrupt enable routes each underflow to an interrupt.
// [RULE13] Writing zero to the flag bit clears the flag.
// [RULE14] Timer mode underflow reloads the counter and keeps counting.
// [RULE15] Correct feed loads counter; bad feeds ignored in timer mode.
// [RULE16] With reset enabled software feeds before every underflow.
// [RULE17] Oscillator selected keeps oscillator and watchdog running.
// [RULE18] Peripheral clock selected means power-down stops the count.
// [RULE19] Feed is A5 then 5A, no writes between; bad feed resets.
// [RULE20] Underflow with reset enabled asserts the watchdog reset.
// [RULE21] Counter runs while the run bit is one, stops at zero.
// [RULE22] Safety lock forces select and run, allows one write each.
// [RULE23] Writes, feeds and flag updates are never lost or doubled.
`include "wtcm_regs.svh"
`default_nettype none

module wtcm_core
    import wtcm_pkg::*;
#(
    parameter int OSC_DIV = `WTCM_OSC_DIV
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic pclk_en_i,
    input wire logic power_down_i,
    input wire logic reset_function_enable_i,
    input wire logic safety_lock_enable_i,
    input wire logic watchdog_irq_enable_i,
    input wire logic [7:0] wr_data_i,
    input wire logic ctrl_wr_i,
    input wire logic reload_wr_i,
    input wire logic feed1_wr_i,
    input wire logic feed2_wr_i,
    input wire logic other_wr_i,
    output logic [7:0] control_o,
    output logic [7:0] reload_value_o,
    output logic [7:0] count_o,
    output logic timeout_flag_o,
    output logic irq_o,
    output logic wd_reset_o,
    output logic clock_source_select_o,
    output logic switch_busy_o,
    output logic osc_running_o
);

    // ==========================================================
    // Elaboration check
    if (OSC_DIV < 2 || OSC_DIV > 31)
    begin : g_bad_div
        $error("OSC_DIV must lie in 2..31");
    end

    // ==========================================================
    // Declarations
    logic [7:0] watchdog_control_reg, watchdog_control_next;
    logic [7:0] shadow_reg, shadow_next;
    logic [7:0] reload_value_reg, reload_value_next;
    logic timeout_flag_reg, timeout_flag_next;
    logic feed_armed_reg, feed_armed_next;
    logic ctl_once_reg, ctl_once_next;
    logic reload_once_reg, reload_once_next;
    logic wd_reset_reg, wd_reset_next;
    logic irq_reg, irq_next;
    logic [11:0] pre_reg, pre_next;
    logic [7:0] count_reg, count_next;
    logic uf_pend_reg, uf_pend_next;
    wtcm_sw_e sw_state_reg, sw_state_next;
    logic cur_src_reg, cur_src_next;
    logic tgt_src_reg, tgt_src_next;
    logic [1:0] sw_cnt_reg, sw_cnt_next;
    logic [4:0] osc_div_reg, osc_div_next;
    logic osc_run_reg, osc_run_next;

    logic safety, any_wr, feed1_good, feed_ok, bad_feed;
    logic ctl_ok, reload_ok, run_eff, osc_on, osc_tick, pclk_live;
    logic old_tick, new_tick, wd_tick, underflow, fed_src;
    logic [2:0] tap;
    logic [11:0] pre_mask;

    // ==========================================================
    // Feed detection and write acceptance
    assign safety = reset_function_enable_i & safety_lock_enable_i;
    assign any_wr = ctrl_wr_i | reload_wr_i | feed1_wr_i | feed2_wr_i
                    | other_wr_i;
    assign feed1_good = feed1_wr_i && wr_data_i == `WTCM_FEED1_KEY;
    assign feed_ok = feed2_wr_i && feed_armed_reg
                     && wr_data_i == `WTCM_FEED2_KEY; // RULE19
    // Any write other than the completing one spoils an armed feed
    assign bad_feed = (feed_armed_reg && any_wr && !feed_ok)
                      || (feed2_wr_i && !feed_ok)
                      || (feed1_wr_i && !feed1_good); // RULE19
    assign ctl_ok = ctrl_wr_i && !(safety && ctl_once_reg); // RULE22
    assign reload_ok = reload_wr_i && !(safety && reload_once_reg); // RULE22

    // Safety lock overrides the run bit of the shadow and the select bit of the control register
    assign run_eff = shadow_reg[`WTCM_RUN_BIT] | safety; // RULE21 RULE22
    assign fed_src = watchdog_control_reg[`WTCM_CLK_BIT] | safety; // RULE22
    assign tap = shadow_reg[`WTCM_TAP_MSB:`WTCM_TAP_LSB];
    assign pre_mask = 12'hfff >> (3'd7 - tap); // RULE1

    // ==========================================================
    // Clock sources
    assign pclk_live = pclk_en_i & ~power_down_i; // RULE18
    // Oscillator only sleeps when it is not the active source
    assign osc_on = ~power_down_i | cur_src_reg; // RULE17 RULE18
    assign osc_tick = osc_on
                      && osc_div_reg == 5'(OSC_DIV - 1); // RULE2
    assign old_tick = cur_src_reg ? osc_tick : pclk_live; // RULE3
    assign new_tick = tgt_src_reg ? osc_tick : pclk_live; // RULE3
    // No ticks leave the mux during a switch: glitch-free hand-over
    assign wd_tick = sw_state_reg == WTCM_SW_RUN && old_tick; // RULE5

    always_comb
    begin
        osc_div_next = osc_div_reg;
        osc_run_next = osc_on;
        if (!osc_on || osc_div_reg == 5'(OSC_DIV - 1))
        begin
            osc_div_next = 5'd0;
        end
        else
        begin
            osc_div_next = osc_div_reg + 5'd1; // RULE2
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            osc_div_reg <= 5'd0;
            osc_run_reg <= 1'b1;
        end
        else
        begin
            osc_div_reg <= osc_div_next;
            osc_run_reg <= osc_run_next;
        end
    end

    // ==========================================================
    // Source switch sequencer
    always_comb
    begin
        sw_state_next = sw_state_reg;
        cur_src_next = cur_src_reg;
        tgt_src_next = tgt_src_reg;
        sw_cnt_next = sw_cnt_reg;
        if (feed_ok)
        begin
            tgt_src_next = fed_src; // RULE4
            if (fed_src != cur_src_reg && sw_state_reg == WTCM_SW_RUN)
            begin
                sw_state_next = WTCM_SW_DESEL;
                sw_cnt_next = 2'd0;
            end
        end
        else
        begin
            case (sw_state_reg)
                WTCM_SW_DESEL:
                begin
                    // Old source stopped (the peripheral clock when switching to the oscillator): switch waits here
                    if (old_tick)
                    begin
                        sw_cnt_next = sw_cnt_reg + 2'd1; // RULE9
                        if (sw_cnt_reg + 2'd1 == `WTCM_SYNC_TICKS)
                        begin
                            sw_state_next = WTCM_SW_SEL; // RULE5
                            sw_cnt_next = 2'd0;
                        end
                    end
                end
                WTCM_SW_SEL:
                begin
                    if (new_tick)
                    begin
                        sw_cnt_next = sw_cnt_reg + 2'd1;
                        if (sw_cnt_reg + 2'd1 == `WTCM_SYNC_TICKS)
                        begin
                            sw_state_next = WTCM_SW_RUN; // RULE5
                            cur_src_next = tgt_src_reg;
                            sw_cnt_next = 2'd0;
                        end
                    end
                end
                default:
                begin
                    sw_state_next = WTCM_SW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sw_state_reg <= WTCM_SW_RUN;
            cur_src_reg <= 1'b1;
            tgt_src_reg <= 1'b1;
            sw_cnt_reg <= 2'd0;
        end
        else
        begin
            sw_state_reg <= sw_state_next;
            cur_src_reg <= cur_src_next;
            tgt_src_reg <= tgt_src_next;
            sw_cnt_reg <= sw_cnt_next;
        end
    end

    // ==========================================================
    // Prescaler and down counter
    always_comb
    begin
        pre_next = pre_reg;
        count_next = count_reg;
        uf_pend_next = uf_pend_reg;
        underflow = 1'b0;
        if (feed_ok)
        begin
            pre_next = 12'd0; // RULE6
            count_next = reload_value_reg; // RULE15
            uf_pend_next = 1'b0;
        end
        else if (wd_tick && run_eff)
        begin
            if (uf_pend_reg)
            begin
                // The extra tick of the timeout formula
                underflow = 1'b1; // RULE1
                uf_pend_next = 1'b0;
                pre_next = 12'd0;
                count_next = reload_value_reg; // RULE14
            end
            else if (pre_reg == pre_mask)
            begin
                pre_next = 12'd0;
                if (count_reg == 8'd0)
                begin
                    uf_pend_next = 1'b1;
                end
                else
                begin
                    count_next = count_reg - 8'd1; // RULE21
                end
            end
            else
            begin
                pre_next = pre_reg + 12'd1;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pre_reg <= 12'd0;
            count_reg <= `WTCM_RELOAD_RST;
            uf_pend_reg <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_next;
            count_reg <= count_next;
            uf_pend_reg <= uf_pend_next;
        end
    end

    // ==========================================================
    // Registers, feed state, flag and outputs
    always_comb
    begin
        watchdog_control_next = watchdog_control_reg;
        shadow_next = shadow_reg;
        reload_value_next = reload_value_reg;
        timeout_flag_next = timeout_flag_reg;
        ctl_once_next = ctl_once_reg | (ctl_ok & safety);
        reload_once_next = reload_once_reg | (reload_ok & safety);
        feed_armed_next = any_wr ? feed1_good : feed_armed_reg;
        if (ctl_ok)
        begin
            watchdog_control_next = wr_data_i;
            if (!wr_data_i[`WTCM_FLAG_BIT])
            begin
                timeout_flag_next = 1'b0; // RULE13
            end
        end
        if (reload_ok)
        begin
            reload_value_next = wr_data_i;
        end
        if (feed_ok)
        begin
            shadow_next = watchdog_control_reg; // RULE4
            if (reset_function_enable_i)
            begin
                timeout_flag_next = 1'b0;
            end
        end
        else if (!reset_function_enable_i && wd_tick)
        begin
            // Select bit still waits for a feed
            shadow_next = {watchdog_control_reg[7:1],
                           shadow_reg[`WTCM_CLK_BIT]}; // RULE10 RULE4
        end
        // Set wins over a clear in the same cycle
        if (underflow)
        begin
            timeout_flag_next = 1'b1; // RULE11 RULE23
        end
        wd_reset_next = reset_function_enable_i
                        && (underflow || bad_feed); // RULE20 RULE19 RULE15
        irq_next = timeout_flag_next & watchdog_irq_enable_i; // RULE12
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            watchdog_control_reg <= `WTCM_CTL_RST;
            shadow_reg <= `WTCM_CTL_RST;
            reload_value_reg <= `WTCM_RELOAD_RST;
            timeout_flag_reg <= 1'b0;
            feed_armed_reg <= 1'b0;
            ctl_once_reg <= 1'b0;
            reload_once_reg <= 1'b0;
            wd_reset_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            watchdog_control_reg <= watchdog_control_next;
            shadow_reg <= shadow_next;
            reload_value_reg <= reload_value_next;
            timeout_flag_reg <= timeout_flag_next;
            feed_armed_reg <= feed_armed_next;
            ctl_once_reg <= ctl_once_next;
            reload_once_reg <= reload_once_next;
            wd_reset_reg <= wd_reset_next;
            irq_reg <= irq_next;
        end
    end

    // ==========================================================
    // Outputs
    assign control_o = {watchdog_control_reg[7:3],
                        watchdog_control_reg[`WTCM_RUN_BIT] | safety,
                        timeout_flag_reg,
                        watchdog_control_reg[`WTCM_CLK_BIT] | safety};
    assign reload_value_o = reload_value_reg;
    assign count_o = count_reg;
    assign timeout_flag_o = timeout_flag_reg;
    assign irq_o = irq_reg;
    assign wd_reset_o = wd_reset_reg;
    assign clock_source_select_o = cur_src_reg;
    assign switch_busy_o = sw_state_reg != WTCM_SW_RUN;
    assign osc_running_o = osc_run_reg;

endmodule

`default_nettype wire

/* File: src/wtcm_regs.svh */
// Bit positions, reset values, keys and timing counts of the watchdog.
// Assumes the includer compiles it once per unit; guarded anyway.
`ifndef WTCM_REGS_SVH
`define WTCM_REGS_SVH

// ==========================================================
// Control register fields
`define WTCM_CLK_BIT 0
`define WTCM_FLAG_BIT 1
`define WTCM_RUN_BIT 2
`define WTCM_TAP_LSB 5
`define WTCM_TAP_MSB 7
`define WTCM_CTL_RST 8'he5
`define WTCM_RELOAD_RST 8'hff

// ==========================================================
// Feed keys
`define WTCM_FEED1_KEY 8'ha5
`define WTCM_FEED2_KEY 8'h5a

// ==========================================================
// Timing
`define WTCM_SYS_CLK_HZ 10000000
`define WTCM_OSC_HZ 400000
`define WTCM_OSC_DIV (`WTCM_SYS_CLK_HZ / `WTCM_OSC_HZ)
`define WTCM_SYNC_TICKS 2'd2

`endif

/* File: src/wtcm_pkg.sv */
// Types shared by the watchdog design.
// Assumes nothing of its surroundings.
`default_nettype none

package wtcm_pkg;
    typedef enum logic [1:0] {
        WTCM_SW_RUN = 2'b00,
        WTCM_SW_DESEL = 2'b01,
        WTCM_SW_SEL = 2'b10
    } wtcm_sw_e;
endpackage

`default_nettype wire

/* File: tb/wtcm_core_asserts.sv */
// Checker for the watchdog core, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module wtcm_core_asserts
#(
    parameter int OSC_DIV = 25
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic power_down_i,
    input wire logic reset_function_enable_i,
    input wire logic safety_lock_enable_i,
    input wire logic watchdog_irq_enable_i,
    input wire logic [7:0] wr_data_i,
    input wire logic ctrl_wr_i,
    input wire logic feed1_wr_i,
    input wire logic feed2_wr_i,
    input wire logic [7:0] control_o,
    input wire logic [7:0] reload_value_o,
    input wire logic [7:0] count_o,
    input wire logic timeout_flag_o,
    input wire logic irq_o,
    input wire logic wd_reset_o,
    input wire logic clock_source_select_o,
    input wire logic switch_busy_o
);
    logic lk;
    logic pd_pclk;
    assign lk = reset_function_enable_i && safety_lock_enable_i;
    assign pd_pclk = power_down_i && !clock_source_select_o
        && !switch_busy_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // =====
    // Properties
    a_irq_flag: assert property ($rose(timeout_flag_o) &&
        watchdog_irq_enable_i |-> ##[0:1] irq_o) else $error("irq late");
    a_ctrl_write: assert property (ctrl_wr_i && !lk |=>
        control_o[7:3] == $past(wr_data_i[7:3])) else $error("ctrl lost");
    a_lock_force: assert property (lk [*2] |->
        control_o[2] && control_o[0]) else $error("lock bits");
    a_feed_load: assert property ($past(feed1_wr_i &&
        wr_data_i == 8'ha5) && feed2_wr_i && wr_data_i == 8'h5a
        |=> count_o == $past(reload_value_o)) else $error("feed load");
    a_timer_quiet: assert property (!reset_function_enable_i [*3]
        |-> !wd_reset_o) else $error("timer reset");
    a_reset_pulse: assert property (wd_reset_o |=> !wd_reset_o)
        else $error("reset width");
    // Ticks are gated in the same clock; checked after two cycles of power-down
    a_pdown_stop: assert property (pd_pclk [*2] ##0
        !feed2_wr_i |=> $stable(count_o)) else $error("pd count");
    a_run_stop: assert property ((!reset_function_enable_i &&
        !control_o[2]) [*3] ##0 !feed2_wr_i |=> $stable(count_o))
        else $error("run count");
    cover property ($rose(timeout_flag_o));
    cover property ($rose(wd_reset_o));
    cover property ($fell(switch_busy_o));
endmodule

bind wtcm_core wtcm_core_asserts #(.OSC_DIV(OSC_DIV)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .power_down_i(power_down_i),
    .reset_function_enable_i(reset_function_enable_i),
    .safety_lock_enable_i(safety_lock_enable_i),
    .watchdog_irq_enable_i(watchdog_irq_enable_i),
    .wr_data_i(wr_data_i), .ctrl_wr_i(ctrl_wr_i),
    .feed1_wr_i(feed1_wr_i), .feed2_wr_i(feed2_wr_i),
    .control_o(control_o), .reload_value_o(reload_value_o),
    .count_o(count_o), .timeout_flag_o(timeout_flag_o), .irq_o(irq_o),
    .wd_reset_o(wd_reset_o),
    .clock_source_select_o(clock_source_select_o),
    .switch_busy_o(switch_busy_o));
`default_nettype wire

/* File: tb/test_watchdog_timer_clock_and_timer_mode.sv */
// Self-checking bench for the watchdog core.
// Assumes a pclk tick every clock and an oscillator divider of 2.
`default_nettype none
module test_watchdog_timer_clock_and_timer_mode;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, pen = 1, pd = 0, rfe = 1, sle = 1, ien = 1;
    logic cw = 0, rw = 0, f1 = 0, f2 = 0, ow = 0, fd = 0, rd = 0;
    logic [7:0] wd = 8'h00, ctl, rld, cnt;
    logic flg, irq, wdr, sel, busy, oscr;
    logic [31:0] seed = 32'h8e44;
    int failures = 0, check_count = 0, since = 0, quiet = 0, t, r;
    int per_q[$], rst_q[$];
    always #50 clk = ~clk;
    wtcm_core #(.OSC_DIV(2)) dut (
        .sys_clk_i(clk), .rst_i(rst), .pclk_en_i(pen), .power_down_i(pd),
        .reset_function_enable_i(rfe), .safety_lock_enable_i(sle),
        .watchdog_irq_enable_i(ien), .wr_data_i(wd), .ctrl_wr_i(cw),
        .reload_wr_i(rw), .feed1_wr_i(f1), .feed2_wr_i(f2),
        .other_wr_i(ow), .control_o(ctl), .reload_value_o(rld),
        .count_o(cnt), .timeout_flag_o(flg), .irq_o(irq),
        .wd_reset_o(wdr), .clock_source_select_o(sel),
        .switch_busy_o(busy), .osc_running_o(oscr));
    // =====
    // Helpers
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task cmp_val(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Timing allows two clocks of gating slack
    task cmp_win(input int g, input int e);
        check_count++;
        if (g < e || g > e + 2)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task close_out();
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task wr(input int k, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        cw <= k == 0;
        rw <= k == 1;
        f1 <= k == 2;
        f2 <= k == 3;
        ow <= k == 4;
        @(posedge clk);
        {cw, rw, f1, f2, ow} <= 5'h00;
    endtask
    task feed();
        @(posedge clk);
        wd <= 8'ha5;
        f1 <= 1'h1;
        @(posedge clk);
        wd <= 8'h5a;
        {f1, f2} <= 2'h1;
        @(posedge clk);
        f2 <= 1'h0;
    endtask
    task wt(input int k, input logic v);
        int n;
        n = 0;
        @(negedge clk);
        while ((k == 0 ? flg : busy) !== v && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 9000)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, n, v);
        end
    endtask
    // =====
    // Result monitor
    always @(posedge clk)
    begin
        since <= f2 ? 0 : since + 1;
        quiet <= (cw | rw | f1 | f2 | ow) ? 0 : quiet + 1;
        fd <= flg;
        rd <= wdr;
        if (flg && !fd)
        begin
            cmp_win(since, per_q.size() ? per_q.pop_front() : -1);
            cmp_val(cnt, rld);
            cmp_val(irq, ien);
        end
        // Pulse trails its cause by one register stage
        if (wdr && !rd)
            cmp_win(quiet + 1,
                    rst_q.size() ? rst_q.pop_front() : -1);
    end
    // =====
    // Scenarios
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        cmp_val(ctl, 8'he5);
        cmp_val(rld, 8'hff);
        cmp_val({sel, oscr}, 8'h03);
        wr(0, 8'h00);
        @(negedge clk);
        cmp_val(ctl, 8'h05);
        wr(0, 8'he0);
        wr(1, 8'h10);
        wr(1, 8'h20);
        @(negedge clk);
        cmp_val(ctl, 8'h05);
        cmp_val(rld, 8'h10);
        @(posedge clk);
        {rst, rfe, sle} <= 3'h4;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        wr(0, 8'h04);
        @(negedge clk);
        cmp_val(sel, 8'h01);
        feed();
        @(negedge clk);
        cmp_val(busy, 8'h01);
        wt(1, 1'h0);
        cmp_val(sel, 8'h00);
        for (t = 0; t < 3; t++)
        begin
            r = rnd() % 4;
            wr(1, r[7:0]);
            ien <= t[0];
            wr(0, {t[2:0], 5'h04});
            per_q.push_back((32 << t) * (r + 1) + 1);
            feed();
            wt(0, 1'h1);
            wr(0, {t[2:0], 5'h04});
            @(negedge clk);
            cmp_val(flg, 8'h00);
        end
        wr(1, 8'h80);
        feed();
        wr(0, 8'h00);
        wr(1, 8'h40);
        wr(2, 8'ha5);
        wr(4, 8'h00);
        wr(3, 8'h5a);
        @(negedge clk);
        cmp_val(cnt > 8'h40, 8'h01);
        wr(0, 8'h04);
        per_q.push_back(32 * 65 + 1 + 8);
        feed();
        pd <= 1'h1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp_val(oscr, 8'h00);
        repeat (4) @(posedge clk);
        pd <= 1'h0;
        wt(0, 1'h1);
        @(posedge clk);
        rfe <= 1'h1;
        rst_q.push_back(1);
        wr(2, 8'ha5);
        wr(0, 8'h04);
        wr(1, 8'h00);
        per_q.push_back(33);
        rst_q.push_back(34);
        feed();
        wt(0, 1'h1);
        repeat (3) @(posedge clk);
        rfe <= 1'h0;
        repeat (4) @(posedge clk);
        cmp_val(8'(per_q.size() + rst_q.size()), 8'h00);
        close_out();
    end
    initial
    begin
        #2000000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
